//--- iwp_pkg.sv
// Package: constants, register map and types for the interrupt detect and power control block
package iwp_pkg;
	// Register byte addresses
	localparam logic [7:0] IWP_ADDR_PWR   = 8'h87;
	localparam logic [7:0] IWP_ADDR_TIRQ  = 8'h88;
	localparam logic [7:0] IWP_ADDR_IOCTL = 8'hF8;
	localparam logic [7:0] IWP_ADDR_ENA   = 8'hA8;
	localparam logic [7:0] IWP_ADDR_PRI   = 8'hB8;
	// Power control fields
	localparam int IWP_PWR_IDLE = 0;
	localparam int IWP_PWR_SPD  = 1;
	localparam int IWP_PWR_WSEL = 5;
	localparam int IWP_PWR_HPDE = 6;
	// Timer and request control fields
	localparam int IWP_TI_EDGE0 = 0;
	localparam int IWP_TI_FLAG0 = 1;
	localparam int IWP_TI_EDGE1 = 2;
	localparam int IWP_TI_FLAG1 = 3;
	// I/O control fields
	localparam int IWP_IO_FLOAT = 0;
	// Enable register fields
	localparam int IWP_EN_X0  = 0;
	localparam int IWP_EN_X1  = 2;
	localparam int IWP_EN_ALL = 7;
	// Reset values
	localparam logic [7:0] IWP_RST_BYTE = 8'h00;
	// Machine cycle: six states of two oscillator periods each
	localparam logic [3:0] IWP_PHASES = 4'hC;
	localparam logic [3:0] IWP_PH_S3  = 4'h4;
	localparam logic [3:0] IWP_PH_S4  = 4'h6;
	localparam logic [3:0] IWP_PH_S5  = 4'h8;
	localparam logic [3:0] IWP_PH_S6  = 4'hA;
	localparam logic [3:0] IWP_PH_END = 4'hB;
	// Oscillator period in ns, and clocks per oscillator period
	localparam int IWP_CLK_NS = 4;
	localparam int IWP_OSC_NS = 8;
	localparam int IWP_OSC_DIV = (IWP_OSC_NS + IWP_CLK_NS - 1) / IWP_CLK_NS;
	localparam logic [3:0] IWP_OSC_MAX = 4'(IWP_OSC_DIV - 1);
	// Power mode states, Gray coded
	typedef enum logic [1:0] {
		IWP_RUN  = 2'h0,
		IWP_IDLE = 2'h1,
		IWP_DOWN = 2'h3
	} iwp_mode_t;
endpackage : iwp_pkg

//--- iwp_edge.sv
// Edge detector for one external request pin: two latches, differentiator, set-reset flop
`timescale 1ns/1ns
`default_nettype none
module iwp_edge
	import iwp_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic ce,
	// Timing strobes
	input  wire logic st_s5,
	input  wire logic st_s3,
	input  wire logic st_s4,
	// Pin level, already synchronised
	input  wire logic pin_s,
	// Set pulse toward the request flag
	output logic      set_p
);
	typedef struct packed {
		logic l1;   // First stage: low seen at S5
		logic l2;   // Second stage copy
		logic arm;  // Re-armed once a high was latched
		logic rs;   // Set-reset flop
		logic set;  // Set pulse at S3
	} iwp_edge_t;
	iwp_edge_t s_r, s_nxt;

	assign set_p = s_r.set;

	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.set = 1'b0;
		if (st_s5) begin
			s_nxt.l1 = ~pin_s;
			if (pin_s) begin
				s_nxt.arm = 1'b1;
			end
		end
		if (st_s3) begin
			s_nxt.l2 = s_r.l1;
			if (s_r.l1 && !s_r.l2 && s_r.arm) begin
				s_nxt.rs = 1'b1;
				s_nxt.arm = 1'b0;
			end
		end
		// flag at S3, clear at S4
		if (st_s3 && (s_r.rs || (s_r.l1 && !s_r.l2 && s_r.arm))) begin
			s_nxt.set = 1'b1;
		end
		if (st_s4) begin
			s_nxt.rs = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_r <= '{l1: 1'b0, l2: 1'b0, arm: 1'b1, rs: 1'b0, set: 1'b0};
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	chk_edge_rearm: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && s_r.set) |-> !s_r.arm)
		else $error("edge flag set while still armed");
endmodule : iwp_edge
`default_nettype wire

//--- iwp_top.sv
// Top: request detection, dispatch timing and power modes
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Edge select bits pick falling-edge detection
// - Edge mode samples pin low at S5
// - Second latch differentiates, sets RS flop
// - Flag set at S3, flop cleared S4
// - Ignore edges until high is sampled
// - Ordinary instruction: dispatch right after it
// - Enable/priority write delays dispatch one instruction
// - Copying enable/priority out is not manipulation
// - After return, one main instruction first
// - After return plus manipulation, two instructions
// - Registers hold while oscillator stopped
// - Idle bit gates CPU clock, oscillator runs
// - Peripherals and interrupts keep running in idle
// - Soft power-down stops oscillator and CPU
// - Armed power-fail falling edge in run mode stops everything
// - Float bit tri-states ports in power-down
// - Exit by reset, interrupt, or source event
// - Wake select zero needs enabled request
// - Wake select one wakes on any flag
// - Level mode sets S3, clears S6
module iwp_top
	import iwp_pkg::*;
(
	// Clock, reset, enable
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// External pins
	input  wire logic       ext_req0_pin,
	input  wire logic       ext_req1_pin,
	input  wire logic       power_fail_detect_pin,
	// Core instruction status
	input  wire logic       instr_done,
	input  wire logic       instr_manip,
	input  wire logic       instr_copy_only,
	input  wire logic       instr_return_from_irq,
	input  wire logic       irq_ack,
	// Core and clock control outputs
	output logic            irq_call,
	output logic      [1:0] irq_src,
	output logic            cpu_clk_en,
	output logic            osc_en,
	output logic            periph_run,
	output logic            port_oe_n,
	output logic            wake_resume
);
	////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [1:0] r0, r1, rp;   // Synchronisers
		logic       hp_last;      // Power-fail previous level
		logic [3:0] osc;          // Oscillator period divider
		logic [3:0] ph;           // Machine cycle phase
		logic [7:0] pwr;          // Power control
		logic [7:0] tirq;         // Timer and request control
		logic [7:0] ioc;          // I/O control
		logic [7:0] ena;          // Enable shadow
		logic [7:0] pri;          // Priority shadow
		logic [1:0] hold;         // Instructions to wait before dispatch
		logic       call;         // Dispatch request
		logic [1:0] src;          // Source number
		iwp_mode_t  mode;         // Power mode
		logic       floatp;       // Ports floated
		logic       wake;         // Resume pulse
		logic [7:0] rdata;        // Read data
	} iwp_state_t;
	iwp_state_t s_r, s_nxt;

	// Decode the phase strobe for one state boundary
	function automatic logic at_ph(input logic [3:0] ph, input logic [3:0] osc, input logic [3:0] want);
		at_ph = (ph == want) && (osc == IWP_OSC_MAX);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Timing strobes and edge detectors
	logic st_s3, st_s4, st_s5, st_s6;
	logic osc_tick;                 // One oscillator period
	logic osc_on;                   // Oscillator running, strobes may fire
	logic set0_p, set1_p;           // Edge detector outputs
	logic pin0_s, pin1_s, hp_s;     // Synchronised pins
	logic pend0, pend1;             // Flags that can be served
	logic wake_en, wake_any;        // Wake causes
	logic rdv;                      // Read data choice

	assign osc_tick = (s_r.osc == IWP_OSC_MAX);
	// A frozen divider must not hold a strobe high through power-down
	assign osc_on = (s_r.mode != IWP_DOWN);
	assign st_s3 = at_ph(s_r.ph, s_r.osc, IWP_PH_S3) && osc_on;
	assign st_s4 = at_ph(s_r.ph, s_r.osc, IWP_PH_S4) && osc_on;
	assign st_s5 = at_ph(s_r.ph, s_r.osc, IWP_PH_S5) && osc_on;
	assign st_s6 = at_ph(s_r.ph, s_r.osc, IWP_PH_S6) && osc_on;
	assign pin0_s = s_r.r0[1];
	assign pin1_s = s_r.r1[1];
	assign hp_s   = s_r.rp[1];
	assign rdv    = 1'b0;

	// the source keeps each level twelve periods; one sample each cycle suffices
	// Request 0 edge detector
	iwp_edge u_edge0 (
		.clock (clock),
		.rst_n (rst_n),
		.ce    (ce),
		.st_s5 (st_s5),
		.st_s3 (st_s3),
		.st_s4 (st_s4),
		.pin_s (pin0_s),
		.set_p (set0_p)
	);
	// Request 1 edge detector
	iwp_edge u_edge1 (
		.clock (clock),
		.rst_n (rst_n),
		.ce    (ce),
		.st_s5 (st_s5),
		.st_s3 (st_s3),
		.st_s4 (st_s4),
		.pin_s (pin1_s),
		.set_p (set1_p)
	);

	// Servable requests: flag, own enable, global enable
	assign pend0 = s_r.tirq[IWP_TI_FLAG0] && s_r.ena[IWP_EN_X0] && s_r.ena[IWP_EN_ALL];
	assign pend1 = s_r.tirq[IWP_TI_FLAG1] && s_r.ena[IWP_EN_X1] && s_r.ena[IWP_EN_ALL];
	assign wake_en  = pend0 || pend1;
	assign wake_any = s_r.tirq[IWP_TI_FLAG0] || s_r.tirq[IWP_TI_FLAG1];

	////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.wake = 1'b0;
		s_nxt.rdata = IWP_RST_BYTE;
		// Synchronisers
		s_nxt.r0 = {s_r.r0[0], ext_req0_pin};
		s_nxt.r1 = {s_r.r1[0], ext_req1_pin};
		s_nxt.rp = {s_r.rp[0], power_fail_detect_pin};
		s_nxt.hp_last = hp_s;
		// timing stops with the oscillator, registers hold
		if (s_r.mode != IWP_DOWN) begin
			s_nxt.osc = osc_tick ? 4'h0 : s_r.osc + 4'h1;
			if (osc_tick) begin
				s_nxt.ph = (s_r.ph == IWP_PH_END) ? 4'h0 : s_r.ph + 4'h1;
			end
		end
		// Register write; flags set by hardware below win
		if (reg_wr) begin
			case (reg_addr)
				IWP_ADDR_PWR:   s_nxt.pwr  = reg_wdata;
				IWP_ADDR_TIRQ:  s_nxt.tirq = reg_wdata;
				IWP_ADDR_IOCTL: s_nxt.ioc  = reg_wdata;
				IWP_ADDR_ENA:   s_nxt.ena  = reg_wdata;
				IWP_ADDR_PRI:   s_nxt.pri  = reg_wdata;
				default:        s_nxt.rdata = IWP_RST_BYTE;
			endcase
		end
		// Register read, data valid next cycle
		if (reg_rd) begin
			case (reg_addr)
				IWP_ADDR_PWR:   s_nxt.rdata = s_r.pwr;
				IWP_ADDR_TIRQ:  s_nxt.rdata = s_r.tirq;
				IWP_ADDR_IOCTL: s_nxt.rdata = s_r.ioc;
				IWP_ADDR_ENA:   s_nxt.rdata = s_r.ena;
				IWP_ADDR_PRI:   s_nxt.rdata = s_r.pri;
				default:        s_nxt.rdata = {7'h00, rdv};
			endcase
		end
		// level mode clears at S6 each cycle
		if (st_s6) begin
			if (!s_r.tirq[IWP_TI_EDGE0]) s_nxt.tirq[IWP_TI_FLAG0] = 1'b0;
			if (!s_r.tirq[IWP_TI_EDGE1]) s_nxt.tirq[IWP_TI_FLAG1] = 1'b0;
		end
		// level mode sets at S3 from low
		if (st_s3) begin
			if (!s_r.tirq[IWP_TI_EDGE0] && !pin0_s) s_nxt.tirq[IWP_TI_FLAG0] = 1'b1;
			if (!s_r.tirq[IWP_TI_EDGE1] && !pin1_s) s_nxt.tirq[IWP_TI_FLAG1] = 1'b1;
		end
		// edge select routes the detector output
		if (s_r.tirq[IWP_TI_EDGE0] && set0_p) s_nxt.tirq[IWP_TI_FLAG0] = 1'b1;
		if (s_r.tirq[IWP_TI_EDGE1] && set1_p) s_nxt.tirq[IWP_TI_FLAG1] = 1'b1;
		// Dispatch timing at instruction boundaries
		if (irq_ack) begin
			s_nxt.call = 1'b0;
		end else if (instr_done && s_r.mode == IWP_RUN) begin
			if (instr_return_from_irq) begin
				s_nxt.hold = 2'h1;
				s_nxt.call = 1'b0;
			end else if (instr_manip && !instr_copy_only) begin
				s_nxt.hold = 2'h1;
				s_nxt.call = 1'b0;
			end else begin
				// The one skipped boundary has passed; this one may call
				if (s_r.hold != 2'h0) begin
					s_nxt.hold = s_r.hold - 2'h1;
				end
				s_nxt.call = pend0 || pend1;
				s_nxt.src  = pend0 ? 2'h0 : 2'h1;
			end
		end
		// Power mode machine
		case (s_r.mode)
			IWP_RUN: begin
				// float ports if armed before entry
				if (s_r.pwr[IWP_PWR_SPD]) begin
					s_nxt.mode = IWP_DOWN;
					s_nxt.floatp = s_r.ioc[IWP_IO_FLOAT];
				end else if (s_r.pwr[IWP_PWR_HPDE] && s_r.hp_last && !hp_s) begin
					s_nxt.mode = IWP_DOWN;
					s_nxt.floatp = s_r.ioc[IWP_IO_FLOAT];
				// idle bit stops the CPU clock
				end else if (s_r.pwr[IWP_PWR_IDLE]) begin
					s_nxt.mode = IWP_IDLE;
				end
			end
			IWP_IDLE, IWP_DOWN: begin
				// wake by interrupt or source event
				// wake select one wakes on any flag
				if (wake_en || (s_r.pwr[IWP_PWR_WSEL] && wake_any)) begin
					s_nxt.mode = IWP_RUN;
					s_nxt.floatp = 1'b0;
					s_nxt.wake = !wake_en;
					// clear the mode bits on wake
					s_nxt.pwr[IWP_PWR_IDLE] = 1'b0;
					s_nxt.pwr[IWP_PWR_SPD]  = 1'b0;
				end
			end
			default: begin
				s_nxt.mode = IWP_RUN;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// State register; reset restarts everything
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// Outputs, all from flops
	assign reg_rdata   = s_r.rdata;
	assign irq_call    = s_r.call;
	assign irq_src     = s_r.src;
	assign cpu_clk_en  = (s_r.mode == IWP_RUN);
	assign osc_en      = (s_r.mode != IWP_DOWN);
	assign periph_run  = (s_r.mode != IWP_DOWN);
	assign port_oe_n   = s_r.floatp;
	assign wake_resume = s_r.wake;

	////////////////////////////////////////////////////////////////////
	// Checks
	chk_level_clear: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && st_s6 && !s_r.tirq[IWP_TI_EDGE0] && !st_s3 && !set0_p) |=> !s_r.tirq[IWP_TI_FLAG0])
		else $error("level flag not cleared at S6");
	chk_down_stop: assert property (@(posedge clock) disable iff (!rst_n)
		(s_r.mode == IWP_DOWN) |-> (!osc_en && !cpu_clk_en))
		else $error("oscillator running in power-down");
	chk_idle_osc: assert property (@(posedge clock) disable iff (!rst_n)
		(s_r.mode == IWP_IDLE) |-> (osc_en && !cpu_clk_en))
		else $error("idle clocks wrong");
	chk_wake_clear: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && s_r.mode != IWP_RUN && s_nxt.mode == IWP_RUN) |=> !s_r.pwr[IWP_PWR_SPD])
		else $error("mode bit kept after wake");
	chk_wake_mask: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && s_r.mode == IWP_IDLE && !s_r.pwr[IWP_PWR_WSEL] && !wake_en) |=> (s_r.mode == IWP_IDLE))
		else $error("idle left without enabled request");
	chk_return_from_irq_hold: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && instr_done && instr_return_from_irq && !irq_ack && s_r.mode == IWP_RUN) |=> !irq_call)
		else $error("dispatch right after return");
	chk_manip_hold: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && instr_done && instr_manip && !instr_copy_only && !irq_ack && s_r.mode == IWP_RUN)
		|=> (s_r.hold == 2'h1))
		else $error("manipulation did not delay dispatch");
	chk_float_port: assert property (@(posedge clock) disable iff (!rst_n)
		port_oe_n |-> (s_r.mode == IWP_DOWN))
		else $error("ports floated outside power-down");
endmodule : iwp_top
`default_nettype wire

//--- iwp_src.sv
// Model of the external request sources and the power-fail detector
`timescale 1ns/1ns
`default_nettype none
module iwp_src
	import iwp_pkg::*;
(
	// Clock
	input  wire logic clock,
	// Pins toward the block, pulled high while idle
	output var logic  ext_req0_pin,
	output var logic  ext_req1_pin,
	output var logic  power_fail_detect_pin
);
	////////////////////////////////////////////////////////////////////////
	// Pins start released, so the pull-ups hold them high
	initial begin
		ext_req0_pin          = 1'b1;
		ext_req1_pin          = 1'b1;
		power_fail_detect_pin = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	// Drive one pin to a level just after an edge, then hold it
	// twelve period hold
	task automatic drive(input int idx, input logic lvl, input int len);
		@(posedge clock);
		case (idx)
			0: ext_req0_pin <= lvl;
			1: ext_req1_pin <= lvl;
			default: power_fail_detect_pin <= lvl;
		endcase
		// Never shorter than twelve oscillator periods, so the sampler sees it
		repeat (len + 12 * IWP_OSC_DIV) @(posedge clock);
	endtask
endmodule // iwp_src
`default_nettype wire

//--- tb.sv
// Self-checking bench for the request detect and power control block
`timescale 1ns/1ns
`default_nettype none
module tb
	import iwp_pkg::*;
;
	////////////////////////////////////////////////////////////////////////
	// Stimulus, all given a value at time zero
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        instr_done = 1'b0;
	logic        instr_manip = 1'b0;
	logic        instr_copy_only = 1'b0;
	logic        instr_return_from_irq = 1'b0;
	logic        irq_ack = 1'b0;
	// Pins from the source model
	wire logic   ext_req0_pin, ext_req1_pin, power_fail_detect_pin;
	// Outputs of the block
	wire logic [7:0] reg_rdata;
	wire logic [1:0] irq_src;
	wire logic   irq_call, cpu_clk_en, osc_en, periph_run, port_oe_n, wake_resume;
	// Scoreboard state
	int          errors = 0;
	int          n_checks = 0;
	int          n_wake = 0;
	logic [31:0] seed = 32'h6F7EF906;
	logic [15:0] exp_q[$];
	logic [15:0] ent;
	logic        rd_q = 1'b0;
	////////////////////////////////////////////////////////////////////////
	// Clock at 250 MHz
	always #2 clock = ~clock;
	iwp_top DUT (.clock(clock), .rst_n(rst_n), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_req0_pin(ext_req0_pin),
		.ext_req1_pin(ext_req1_pin), .power_fail_detect_pin(power_fail_detect_pin),
		.instr_done(instr_done), .instr_manip(instr_manip), .instr_copy_only(instr_copy_only),
		.instr_return_from_irq(instr_return_from_irq), .irq_ack(irq_ack), .irq_call(irq_call), .irq_src(irq_src),
		.cpu_clk_en(cpu_clk_en), .osc_en(osc_en), .periph_run(periph_run), .port_oe_n(port_oe_n),
		.wake_resume(wake_resume));
	iwp_src src (.clock(clock), .ext_req0_pin(ext_req0_pin), .ext_req1_pin(ext_req1_pin),
		.power_fail_detect_pin(power_fail_detect_pin));
	////////////////////////////////////////////////////////////////////////
	// Xorshift source of random values
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	// Compare and count
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	// Verdict and end of run
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr    <= 1'b0;
	endtask
	// One-cycle register read, expected data noted for the watcher
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({a, e});
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd   <= 1'b0;
	endtask
	// One finished instruction, then the vector call seen or not
	task automatic ins(input logic m, input logic c, input logic r, input logic e);
		@(posedge clock);
		instr_done      <= 1'b1;
		instr_manip     <= m;
		instr_copy_only <= c;
		instr_return_from_irq      <= r;
		@(posedge clock);
		instr_done      <= 1'b0;
		#1 chk("vector call", {7'h00, e}, {7'h00, irq_call});
		// Take the vector so the call drops again
		if (e) begin
			chk("vector source", 8'h00, {6'h00, irq_src});
			@(posedge clock);
			irq_ack <= 1'b1;
			@(posedge clock);
			irq_ack <= 1'b0;
		end
	endtask
	// Bounded wait for the core clock to come back
	task automatic wait_run();
		int i;
		for (i = 0; i < 100 && cpu_clk_en !== 1'b1; i++)
			@(posedge clock);
		if (i == 100) begin
			errors++;
			conclude();
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// Watcher: read data stand only in the cycle after the strobe
	always @(posedge clock) begin
		rd_q <= reg_rd;
		if (wake_resume === 1'b1)
			n_wake <= n_wake + 1;
		if (rd_q && exp_q.size() > 0) begin
			ent = exp_q.pop_front();
			chk($sformatf("register %h", ent[15:8]), ent[7:0], reg_rdata);
		end
	end
	// Hang guard
	initial begin
		cyc(60000);
		errors++;
		conclude();
	end
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int wk;
		cyc(16);
		rst_n <= 1'b1;
		cyc(1);
		// Run mode and register values after reset
		chk("core clock", 8'h01, {7'h00, cpu_clk_en});
		chk("oscillator", 8'h01, {7'h00, osc_en});
		chk("port float", 8'h00, {7'h00, port_oe_n});
		rd(IWP_ADDR_PWR, IWP_RST_BYTE);
		rd(IWP_ADDR_TIRQ, IWP_RST_BYTE);
		rd(IWP_ADDR_IOCTL, IWP_RST_BYTE);
		// Unmapped place ignores a random write and reads zero
		seed = xs(seed);
		wr({4'h0, seed[3:0]}, seed[15:8]);
		rd({4'h0, seed[3:0]}, 8'h00);
		// Falling edge latched once, re-armed only by a high sample
		wr(IWP_ADDR_TIRQ, 8'h05);
		seed = xs(seed);
		src.drive(0, 1'b0, 36 + int'(seed[3:0]));
		rd(IWP_ADDR_TIRQ, 8'h07);
		wr(IWP_ADDR_TIRQ, 8'h05);
		src.drive(0, 1'b0, 40);
		rd(IWP_ADDR_TIRQ, 8'h05);
		src.drive(0, 1'b1, 40);
		src.drive(0, 1'b0, 40);
		rd(IWP_ADDR_TIRQ, 8'h07);
		// Vector timing against instruction boundaries, request kept pending
		wr(IWP_ADDR_ENA, 8'h81);
		ins(0, 0, 0, 1);
		ins(1, 0, 0, 0);
		ins(0, 0, 0, 1);
		ins(1, 1, 0, 1);
		ins(0, 0, 1, 0);
		ins(0, 0, 0, 1);
		ins(0, 0, 1, 0);
		ins(1, 0, 0, 0);
		ins(0, 0, 0, 1);
		// Idle: core halted while oscillator and request logic run
		wr(IWP_ADDR_ENA, 8'h00);
		wr(IWP_ADDR_TIRQ, 8'h05);
		src.drive(0, 1'b1, 0);
		wr(IWP_ADDR_PWR, 8'h01);
		cyc(3);
		chk("core clock", 8'h00, {7'h00, cpu_clk_en});
		chk("oscillator", 8'h01, {7'h00, osc_en});
		chk("peripherals", 8'h01, {7'h00, periph_run});
		src.drive(1, 1'b0, 40);
		rd(IWP_ADDR_TIRQ, 8'h0D);
		chk("core clock", 8'h00, {7'h00, cpu_clk_en});
		wk = n_wake;
		wr(IWP_ADDR_PWR, 8'h21);
		wait_run();
		cyc(2);
		chk("resume pulses", 8'h01, 8'(n_wake - wk));
		rd(IWP_ADDR_PWR, 8'h20);
		// Soft power-down with floating ports, woken by an enabled flag
		wr(IWP_ADDR_IOCTL, 8'h01);
		wr(IWP_ADDR_TIRQ, 8'h05);
		wr(IWP_ADDR_PWR, 8'h02);
		cyc(3);
		chk("oscillator", 8'h00, {7'h00, osc_en});
		chk("core clock", 8'h00, {7'h00, cpu_clk_en});
		chk("port float", 8'h01, {7'h00, port_oe_n});
		rd(IWP_ADDR_IOCTL, 8'h01);
		wr(IWP_ADDR_ENA, 8'h81);
		wr(IWP_ADDR_TIRQ, 8'h07);
		wait_run();
		chk("port float", 8'h00, {7'h00, port_oe_n});
		rd(IWP_ADDR_PWR, 8'h00);
		// Armed power-fail edge stops everything until reset
		wr(IWP_ADDR_ENA, 8'h00);
		wr(IWP_ADDR_TIRQ, 8'h05);
		wr(IWP_ADDR_PWR, 8'h40);
		src.drive(2, 1'b0, 8);
		chk("oscillator", 8'h00, {7'h00, osc_en});
		chk("port float", 8'h01, {7'h00, port_oe_n});
		rst_n <= 1'b0;
		cyc(2);
		rst_n <= 1'b1;
		cyc(1);
		chk("oscillator", 8'h01, {7'h00, osc_en});
		rd(IWP_ADDR_PWR, 8'h00);
		cyc(4);
		conclude();
	end
endmodule // tb
`default_nettype wire
